// ==== shared/power_mode_pkg.sv ====
// Package of modes, request codes and counts for the power-mode controller
package power_mode_pkg;

  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_MODEM_SLEEP,
    MODE_LIGHT_SLEEP,
    MODE_DEEP_SLEEP,
    MODE_HIBERNATION
  } power_mode_t;

  // Software request codes
  localparam logic [2:0] REQ_ACTIVE      = 3'h0;
  localparam logic [2:0] REQ_MODEM_SLEEP = 3'h1;
  localparam logic [2:0] REQ_LIGHT_SLEEP = 3'h2;
  localparam logic [2:0] REQ_DEEP_SLEEP  = 3'h3;
  localparam logic [2:0] REQ_HIBERNATION = 3'h4;

  // Pattern codes
  localparam logic [1:0] PATTERN_NONE        = 2'h0;
  localparam logic [1:0] PATTERN_ASSOCIATION = 2'h1;
  localparam logic [1:0] PATTERN_SENSOR      = 2'h2;

  // Reset values and widths
  localparam int          WAKE_SOURCES      = 5;
  localparam int          RTC_GPIO_COUNT    = 8;
  localparam int          INTERVAL_WIDTH    = 16;
  localparam logic [15:0] INTERVAL_DEFAULT  = 16'h0064;
  localparam logic [15:0] AWAKE_DEFAULT     = 16'h000a;

  // Wake source bit positions
  localparam int WAKE_MAC   = 0;
  localparam int WAKE_HOST  = 1;
  localparam int WAKE_TIMER = 2;
  localparam int WAKE_EXT   = 3;
  localparam int WAKE_COPRO = 4;

endpackage : power_mode_pkg

// ==== verilog/wake_sync.sv ====
// Two-stage synchroniser bank for asynchronous wake inputs
`timescale 1ns/1ns
module wake_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule : wake_sync

// ==== verilog/power_mode_controller.sv ====
// Power-mode controller: mode sequencing, domain gating and wake handling
`timescale 1ns/1ns
// Summary of operation
// - Active mode keeps the radio powered so the chip can send, receive or listen.
// - Modem-sleep runs the main CPU on its selected clock while baseband and radio are off.
// - Light-sleep pauses the main CPU while the real-time domain and coprocessor keep running.
// - Any MAC, host, timer or external-interrupt wake leaves light-sleep.
// - Deep-sleep powers only the real-time domain, keeps its memory and runs the coprocessor.
// - Hibernation stops the internal oscillator and coprocessor and drops recovery memory.
// - Hibernation keeps only the slow-clock timer and a subset of real-time GPIOs alive.
// - Hibernation ends only on the remaining timer, an enabled real-time GPIO wake or a legal mode request.
// - The association pattern toggles active and a chosen sleep mode at fixed intervals.
// - The sensor pattern holds deep-sleep while the coprocessor measures and decides to wake.
module power_mode_controller
  import power_mode_pkg::*;
#(
  parameter int GPIO_COUNT = RTC_GPIO_COUNT,
  parameter int IWIDTH     = INTERVAL_WIDTH
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  mode_req_valid_in,
  input  wire logic [2:0]            mode_req_in,
  input  wire logic [1:0]            pattern_in,
  input  wire logic                  pattern_light_in,
  input  wire logic [IWIDTH-1:0]     sleep_interval_in,
  input  wire logic [IWIDTH-1:0]     awake_interval_in,
  input  wire logic [1:0]            cpu_clock_sel_in,
  input  wire logic                  wake_mac_in,
  input  wire logic                  wake_host_in,
  input  wire logic                  wake_timer_in,
  input  wire logic                  wake_ext_in,
  input  wire logic                  wake_copro_in,
  input  wire logic [GPIO_COUNT-1:0] rtc_gpio_in,
  input  wire logic [GPIO_COUNT-1:0] rtc_gpio_wake_en_in,
  output logic [2:0]                 mode_out,
  output logic                       cpu_run_out,
  output logic [1:0]                 cpu_clock_sel_out,
  output logic                       radio_power_out,
  output logic                       rtc_power_out,
  output logic                       rtc_memory_retain_out,
  output logic                       copro_enable_out,
  output logic                       osc_enable_out,
  output logic                       slow_timer_enable_out,
  output logic [GPIO_COUNT-1:0]      rtc_gpio_active_out,
  output logic                       wake_out
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [WAKE_SOURCES-1:0] wake_raw;
  logic [WAKE_SOURCES-1:0] wake_level;
  logic [GPIO_COUNT-1:0]   gpio_sync;

  assign wake_raw = {wake_copro_in, wake_ext_in, wake_timer_in, wake_host_in, wake_mac_in};

  wake_sync #(.WIDTH(WAKE_SOURCES)) u_wake_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (wake_raw),
    .sync_out (wake_level)
  );

  wake_sync #(.WIDTH(GPIO_COUNT)) u_gpio_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (rtc_gpio_in),
    .sync_out (gpio_sync)
  );

  // ****************************************
  // Wake qualification
  // ****************************************
  power_mode_t mode;
  power_mode_t next_mode;
  logic [IWIDTH-1:0] interval_count;
  logic [IWIDTH-1:0] next_interval_count;
  logic              interval_done;
  logic              light_wake;
  logic              modem_wake;
  logic              deep_wake;
  logic              hib_wake;
  logic              wake_event;
  logic              pattern_assoc;
  logic              pattern_sensor;
  power_mode_t       req_mode;
  logic              req_ok;
  power_mode_t       assoc_sleep_mode;

  function automatic power_mode_t decode_req(input logic [2:0] code);
    unique case (code)
      REQ_ACTIVE:      decode_req = MODE_ACTIVE;
      REQ_MODEM_SLEEP: decode_req = MODE_MODEM_SLEEP;
      REQ_LIGHT_SLEEP: decode_req = MODE_LIGHT_SLEEP;
      REQ_DEEP_SLEEP:  decode_req = MODE_DEEP_SLEEP;
      REQ_HIBERNATION: decode_req = MODE_HIBERNATION;
      default:         decode_req = MODE_ACTIVE;
    endcase
  endfunction : decode_req

  assign pattern_assoc    = (pattern_in == PATTERN_ASSOCIATION);
  assign pattern_sensor   = (pattern_in == PATTERN_SENSOR);
  assign assoc_sleep_mode = pattern_light_in ? MODE_LIGHT_SLEEP : MODE_MODEM_SLEEP;
  assign req_mode         = decode_req(mode_req_in);
  assign req_ok           = mode_req_valid_in && (mode_req_in <= REQ_HIBERNATION);
  assign interval_done    = (interval_count == '0);

  assign light_wake = wake_level[WAKE_MAC] | wake_level[WAKE_HOST]
                    | wake_level[WAKE_TIMER] | wake_level[WAKE_EXT];
  assign modem_wake = light_wake;
  assign deep_wake  = wake_level[WAKE_TIMER] | wake_level[WAKE_EXT]
                    | wake_level[WAKE_COPRO];
  assign hib_wake   = wake_level[WAKE_TIMER]
                    | (|(gpio_sync & rtc_gpio_wake_en_in));

  always_comb begin
    wake_event = 1'b0;
    unique case (mode)
      MODE_ACTIVE:      wake_event = 1'b0;
      MODE_MODEM_SLEEP: wake_event = modem_wake;
      MODE_LIGHT_SLEEP: wake_event = light_wake;
      MODE_DEEP_SLEEP:  wake_event = deep_wake;
      MODE_HIBERNATION: wake_event = hib_wake;
    endcase
  end

  // ****************************************
  // Mode sequencing
  // ****************************************
  always_comb begin
    next_mode           = mode;
    next_interval_count = interval_done ? '0 : interval_count - 1'b1;
    if (wake_event) begin
      next_mode           = MODE_ACTIVE;
      next_interval_count = awake_interval_in;
    end else if (req_ok) begin
      next_mode           = req_mode;
      next_interval_count = (req_mode == MODE_ACTIVE) ? awake_interval_in : sleep_interval_in;
    end else if (pattern_assoc && interval_done) begin
      if (mode == MODE_ACTIVE) begin
        next_mode           = assoc_sleep_mode;
        next_interval_count = sleep_interval_in;
      end else if (mode == MODE_MODEM_SLEEP || mode == MODE_LIGHT_SLEEP) begin
        next_mode           = MODE_ACTIVE;
        next_interval_count = awake_interval_in;
      end
    end else if (pattern_sensor && mode == MODE_ACTIVE && interval_done) begin
      next_mode = MODE_DEEP_SLEEP;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode           <= MODE_ACTIVE;
      interval_count <= INTERVAL_DEFAULT[IWIDTH-1:0];
    end else begin
      mode           <= next_mode;
      interval_count <= next_interval_count;
    end
  end

  // ****************************************
  // Domain gating
  // ****************************************
  logic                  next_cpu_run;
  logic                  next_radio;
  logic                  next_rtc;
  logic                  next_retain;
  logic                  next_copro;
  logic                  next_osc;
  logic                  next_slow_timer;
  logic [GPIO_COUNT-1:0] next_gpio_active;

  assign next_cpu_run     = (next_mode == MODE_ACTIVE)
                          || (next_mode == MODE_MODEM_SLEEP);
  assign next_radio       = (next_mode == MODE_ACTIVE);
  assign next_rtc         = 1'b1;
  assign next_retain      = (next_mode != MODE_HIBERNATION);
  assign next_copro       = (next_mode != MODE_HIBERNATION);
  assign next_osc         = (next_mode != MODE_HIBERNATION);
  assign next_slow_timer  = 1'b1;
  assign next_gpio_active = (next_mode == MODE_HIBERNATION) ? rtc_gpio_wake_en_in
                                                            : {GPIO_COUNT{1'b1}};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_out              <= 3'h0;
      cpu_run_out           <= 1'b1;
      cpu_clock_sel_out     <= 2'h0;
      radio_power_out       <= 1'b1;
      rtc_power_out         <= 1'b1;
      rtc_memory_retain_out <= 1'b1;
      copro_enable_out      <= 1'b1;
      osc_enable_out        <= 1'b1;
      slow_timer_enable_out <= 1'b1;
      rtc_gpio_active_out   <= '1;
      wake_out              <= 1'b0;
    end else begin
      mode_out              <= next_mode;
      cpu_run_out           <= next_cpu_run;
      cpu_clock_sel_out     <= cpu_clock_sel_in;
      radio_power_out       <= next_radio;
      rtc_power_out         <= next_rtc;
      rtc_memory_retain_out <= next_retain;
      copro_enable_out      <= next_copro;
      osc_enable_out        <= next_osc;
      slow_timer_enable_out <= next_slow_timer;
      rtc_gpio_active_out   <= next_gpio_active;
      wake_out              <= wake_event;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  AST_ACTIVE_RADIO: assert property (
    (mode == MODE_ACTIVE) |-> (radio_power_out && cpu_run_out))
    else $error("radio off in active mode");
  AST_MODEM_GATING: assert property (
    (mode == MODE_MODEM_SLEEP) |-> (cpu_run_out && !radio_power_out))
    else $error("modem-sleep gating wrong");
  AST_RADIO_OFF: assert property (
    (mode != MODE_ACTIVE) |-> !radio_power_out)
    else $error("radio on outside active mode");
  AST_CLOCK_SEL: assert property (
    1'b1 |=> (cpu_clock_sel_out == $past(cpu_clock_sel_in)))
    else $error("cpu clock select not passed on");
  AST_LIGHT_GATING: assert property (
    (mode == MODE_LIGHT_SLEEP) |-> (!cpu_run_out && copro_enable_out && rtc_power_out))
    else $error("light-sleep gating wrong");
  AST_LIGHT_WAKE: assert property (
    (mode == MODE_LIGHT_SLEEP && light_wake) |=> (mode == MODE_ACTIVE && wake_out))
    else $error("light-sleep wake missed");
  AST_DEEP_GATING: assert property (
    (mode == MODE_DEEP_SLEEP) |-> (!cpu_run_out && !radio_power_out && rtc_power_out
      && rtc_memory_retain_out && copro_enable_out))
    else $error("deep-sleep gating wrong");
  AST_HIB_OFF: assert property (
    (mode == MODE_HIBERNATION) |->
      (!osc_enable_out && !copro_enable_out && !rtc_memory_retain_out))
    else $error("hibernation left a domain on");
  AST_AWAKE_DOMAINS: assert property (
    (mode != MODE_HIBERNATION) |-> (osc_enable_out && rtc_memory_retain_out))
    else $error("oscillator or memory off outside hibernation");
  AST_HIB_KEEP: assert property (
    (mode == MODE_HIBERNATION) |->
      (slow_timer_enable_out && rtc_gpio_active_out == $past(rtc_gpio_wake_en_in)))
    else $error("hibernation keep-alive wrong");
  AST_GPIO_AWAKE: assert property (
    (mode != MODE_HIBERNATION) |-> (rtc_gpio_active_out == {GPIO_COUNT{1'b1}}))
    else $error("real-time gpio gated outside hibernation");
  AST_HIB_EXIT: assert property (
    (mode == MODE_HIBERNATION && hib_wake) |=> (mode == MODE_ACTIVE && wake_out))
    else $error("hibernation wake missed");
  AST_HIB_ONLY_WAKE: assert property (
    (mode == MODE_HIBERNATION && !hib_wake && !req_ok) |=> (mode == MODE_HIBERNATION))
    else $error("hibernation left without wake");
  AST_ASSOC_TOGGLE: assert property (
    (pattern_assoc && mode == MODE_ACTIVE && interval_done && !req_ok) |=>
      (mode == $past(assoc_sleep_mode)))
    else $error("association pattern did not sleep");
  AST_ASSOC_RETURN: assert property (
    (pattern_assoc && (mode == MODE_MODEM_SLEEP || mode == MODE_LIGHT_SLEEP) && interval_done
      && !wake_event && !req_ok) |=> (mode == MODE_ACTIVE))
    else $error("association pattern did not wake");
  AST_SENSOR_SLEEP: assert property (
    (pattern_sensor && mode == MODE_ACTIVE && interval_done && !req_ok) |=>
      (mode == MODE_DEEP_SLEEP))
    else $error("sensor pattern did not enter deep-sleep");
  AST_SENSOR_DEEP: assert property (
    (pattern_sensor && mode == MODE_DEEP_SLEEP && !deep_wake && !req_ok) |=>
      (mode == MODE_DEEP_SLEEP))
    else $error("sensor pattern left deep-sleep");
  AST_DEEP_WAKE: assert property (
    (mode == MODE_DEEP_SLEEP && deep_wake) |=> (mode == MODE_ACTIVE && wake_out))
    else $error("deep-sleep wake missed");
  AST_MODEM_WAKE: assert property (
    (mode == MODE_MODEM_SLEEP && modem_wake) |=> (mode == MODE_ACTIVE && wake_out))
    else $error("modem-sleep wake missed");
  AST_WAKE_ACTIVE: assert property (
    wake_event |=> (mode_out == 3'h0 && wake_out))
    else $error("wake did not return to active");
  AST_ACTIVE_QUIET: assert property (
    (mode == MODE_ACTIVE) |=> !wake_out)
    else $error("wake pulse from active mode");
  AST_REQ_TAKEN: assert property (
    (req_ok && !wake_event) |=> (mode == $past(req_mode)))
    else $error("legal request not taken");
  AST_MODE_OUT: assert property (
    1'b1 |-> (mode_out == mode))
    else $error("mode output differs from held mode");
  AST_HOLD: assert property (
    (!wake_event && !req_ok && !pattern_assoc && !pattern_sensor) |=> $stable(mode))
    else $error("mode changed without cause");

  COV_LIGHT_WAKE: cover property (mode == MODE_LIGHT_SLEEP ##1 mode == MODE_ACTIVE);
  COV_MODEM_WAKE: cover property (mode == MODE_MODEM_SLEEP && wake_event);
  COV_HIB_WAKE:   cover property (mode == MODE_HIBERNATION ##1 mode == MODE_ACTIVE);
  COV_ASSOC:      cover property (pattern_assoc && mode == MODE_ACTIVE ##1 mode != MODE_ACTIVE);
  COV_SENSOR:     cover property (pattern_sensor && mode == MODE_DEEP_SLEEP && wake_event);

endmodule : power_mode_controller

// ==== verification/wake_source_model.sv ====
// Model of the wake sources and coprocessor facing the power-mode controller
`timescale 1ns/1ns
module wake_source_model
  import power_mode_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [4:0] fire_in,
  input  wire logic       drop_in,
  input  wire logic [2:0] mode_in,
  input  wire logic       copro_enable_in,
  output logic      [4:0] wake_out
);
  // ****************************************
  // Wake levels held until the chip is active or drop_in clears them
  // ****************************************
  wire logic [4:0] allowed_fire;
  wire logic       clear_all;
  assign allowed_fire = fire_in & {copro_enable_in, 4'hf};
  assign clear_all    = reset_in | drop_in | (mode_in == REQ_ACTIVE);
  always_ff @(posedge clk_in) begin
    wake_out <= clear_all ? 5'h00 : (wake_out | allowed_fire);
  end
endmodule : wake_source_model

// ==== verification/power_mode_controller_tb.sv ====
// Self-checking testbench for the power-mode controller
`timescale 1ns/1ns
module power_mode_controller_tb;
  import power_mode_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        req_valid = 1'b0;
  logic [2:0]  req_code = 3'h0;
  logic [1:0]  pattern = 2'h0;
  logic        pattern_light = 1'b1;
  logic [1:0]  clk_sel = 2'h0;
  logic [4:0]  fire = 5'h00;
  logic        drop = 1'b0;
  logic [7:0]  gpio = 8'h00;
  logic [7:0]  gpio_en = 8'h04;
  logic [4:0]  wake;
  logic [2:0]  mode;
  logic [1:0]  sel_out;
  logic [7:0]  gpio_act;
  logic        cpu_run, radio, rtc_pwr, retain, copro, osc, slow_tmr, wake_pulse;
  logic        pulse_seen;
  int          err_count = 0;
  int          samples_checked = 0;
  always #50 clk_in = ~clk_in;
  power_mode_controller power_mode_controller_i (.clk_in(clk_in), .reset_in(reset_in),
    .mode_req_valid_in(req_valid), .mode_req_in(req_code), .pattern_in(pattern),
    .pattern_light_in(pattern_light), .sleep_interval_in(16'h0005),
    .awake_interval_in(16'h0005), .cpu_clock_sel_in(clk_sel),
    .wake_mac_in(wake[WAKE_MAC]), .wake_host_in(wake[WAKE_HOST]),
    .wake_timer_in(wake[WAKE_TIMER]), .wake_ext_in(wake[WAKE_EXT]),
    .wake_copro_in(wake[WAKE_COPRO]), .rtc_gpio_in(gpio), .rtc_gpio_wake_en_in(gpio_en),
    .mode_out(mode), .cpu_run_out(cpu_run), .cpu_clock_sel_out(sel_out),
    .radio_power_out(radio), .rtc_power_out(rtc_pwr), .rtc_memory_retain_out(retain),
    .copro_enable_out(copro), .osc_enable_out(osc), .slow_timer_enable_out(slow_tmr),
    .rtc_gpio_active_out(gpio_act), .wake_out(wake_pulse));
  wake_source_model wake_source_model_i (.clk_in(clk_in), .reset_in(reset_in),
    .fire_in(fire), .drop_in(drop), .mode_in(mode), .copro_enable_in(copro),
    .wake_out(wake));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic complete_run();
    $display("Checks: %0d, errors: %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #10;
  endtask : tick
  task automatic request(input logic [2:0] code);
    req_valid = 1'b1;
    req_code = code;
    tick(1);
    req_valid = 1'b0;
    tick(1);
  endtask : request
  task automatic fire_src(input int idx);
    fire[idx] = 1'b1;
    tick(1);
    fire = 5'h00;
  endtask : fire_src
  task automatic wait_mode(input logic [2:0] exp, input int limit);
    int n;
    n = 0;
    pulse_seen = 1'b0;
    while (mode !== exp) begin
      tick(1);
      if (wake_pulse === 1'b1) pulse_seen = 1'b1;
      n++;
      if (n > limit) begin
        chk(1'b0, "mode wait timed out");
        complete_run();
      end
    end
  endtask : wait_mode
  task automatic check_mode(input logic [2:0] m);
    chk(mode === m, "mode code");
    chk(radio === (m == REQ_ACTIVE), "radio power");
    chk(cpu_run === (m <= REQ_MODEM_SLEEP), "cpu run");
    chk(rtc_pwr === 1'b1, "rtc power");
    chk(retain === (m != REQ_HIBERNATION), "memory retention");
    chk(copro === (m != REQ_HIBERNATION), "coprocessor enable");
    chk(slow_tmr === 1'b1, "slow timer");
    if (m == REQ_HIBERNATION) begin
      chk(osc === 1'b0, "oscillator off");
      chk(gpio_act === gpio_en, "gpio subset");
    end else begin
      chk(osc === 1'b1, "oscillator on");
      chk(gpio_act === 8'hff, "gpio all active");
    end
  endtask : check_mode
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic run_modes();
    for (int c = 1; c < 4; c++) begin
      request(3'(c));
      check_mode(3'(c));
      request(REQ_ACTIVE);
      check_mode(REQ_ACTIVE);
    end
    clk_sel = 2'h3;
    request(REQ_MODEM_SLEEP);
    chk(sel_out === 2'h3, "cpu clock select");
    for (int c = 5; c < 8; c++) begin
      request(3'(c));
      chk(mode === REQ_MODEM_SLEEP, "illegal code taken");
    end
    request(REQ_ACTIVE);
  endtask : run_modes
  task automatic run_wakes();
    int srcs[4] = '{WAKE_MAC, WAKE_HOST, WAKE_TIMER, WAKE_EXT};
    foreach (srcs[i]) begin
      request(REQ_LIGHT_SLEEP);
      fire_src(srcs[i]);
      wait_mode(REQ_ACTIVE, 8);
      chk(pulse_seen === 1'b1, "light wake pulse");
      tick(4);
    end
    request(REQ_MODEM_SLEEP);
    fire_src(WAKE_MAC);
    wait_mode(REQ_ACTIVE, 8);
    chk(pulse_seen === 1'b1, "modem wake pulse");
    tick(4);
    request(REQ_DEEP_SLEEP);
    fire = 5'h03;
    tick(1);
    fire = 5'h00;
    tick(6);
    chk(mode === REQ_DEEP_SLEEP, "deep-sleep took a radio wake");
    fire_src(WAKE_EXT);
    wait_mode(REQ_ACTIVE, 8);
    chk(pulse_seen === 1'b1, "deep wake pulse");
    tick(4);
    request(REQ_HIBERNATION);
    check_mode(REQ_HIBERNATION);
    fire = 5'h1b;
    gpio = 8'h02;
    tick(10);
    chk(mode === REQ_HIBERNATION, "refused wake acted");
    drop = 1'b1;
    fire = 5'h00;
    gpio = 8'h00;
    tick(1);
    drop = 1'b0;
    tick(4);
    gpio = 8'h04;
    wait_mode(REQ_ACTIVE, 8);
    chk(pulse_seen === 1'b1, "gpio wake pulse");
    gpio = 8'h00;
    tick(4);
    request(REQ_HIBERNATION);
    fire_src(WAKE_TIMER);
    wait_mode(REQ_ACTIVE, 8);
    tick(4);
  endtask : run_wakes
  task automatic run_patterns();
    pattern = PATTERN_ASSOCIATION;
    wait_mode(REQ_LIGHT_SLEEP, 300);
    chk(cpu_run === 1'b0, "association light sleep");
    wait_mode(REQ_ACTIVE, 20);
    pattern_light = 1'b0;
    wait_mode(REQ_MODEM_SLEEP, 20);
    pattern = PATTERN_NONE;
    request(REQ_ACTIVE);
    pattern = PATTERN_SENSOR;
    wait_mode(REQ_DEEP_SLEEP, 300);
    check_mode(REQ_DEEP_SLEEP);
    tick(6);
    chk(mode === REQ_DEEP_SLEEP, "sensor pattern left deep-sleep");
    fire_src(WAKE_COPRO);
    wait_mode(REQ_ACTIVE, 8);
    chk(pulse_seen === 1'b1, "coprocessor wake");
    pattern = PATTERN_NONE;
  endtask : run_patterns
  initial begin
    repeat (16) @(posedge clk_in);
    #10;
    reset_in = 1'b0;
    check_mode(REQ_ACTIVE);
    chk(wake_pulse === 1'b0, "wake idle after reset");
    run_modes();
    run_wakes();
    run_patterns();
    complete_run();
  end
endmodule : power_mode_controller_tb
